// [src/tmr8_defines.vh]
// tmr8_defines.vh: register offsets, field positions, reset values and mode codes
// of the 8-bit timer counter core; assumes inclusion by bare name from src/.
`ifndef TMR8_DEFINES_VH
`define TMR8_DEFINES_VH

// register offsets on the plain register port
`define TMR8_OFS_CTRL_A   4'h0
`define TMR8_OFS_CTRL_B   4'h1
`define TMR8_OFS_COUNT    4'h2
`define TMR8_OFS_CMP_A    4'h3
`define TMR8_OFS_CMP_B    4'h4
`define TMR8_OFS_IRQ_MASK 4'h5
`define TMR8_OFS_IRQ_FLAG 4'h6
`define TMR8_OFS_POWER    4'h7

// ctrl_reg_a fields
`define TMR8_WM_BIT0      0
`define TMR8_WM_BIT1      1
`define TMR8_COM_B_LSB    4
`define TMR8_COM_A_LSB    6
`define TMR8_CTRL_A_MASK  8'hF3

// ctrl_reg_b fields
`define TMR8_CS_LSB       0
`define TMR8_WM_HIGH_BIT  3
`define TMR8_CTRL_B_MASK  8'h0F

// irq flag and mask bit positions
`define TMR8_IRQ_OVF      0
`define TMR8_IRQ_CMP_A    1
`define TMR8_IRQ_CMP_B    2

// power register field
`define TMR8_POWER_BIT    0

// reset values
`define TMR8_RST_BYTE     8'h00
`define TMR8_RST_IRQ      3'h0

// counter extremes
`define TMR8_BOTTOM       8'h00
`define TMR8_MAX          8'hFF

// clock select codes
`define TMR8_CS_STOP      3'h0
`define TMR8_CS_DIV1      3'h1
`define TMR8_CS_DIV8      3'h2
`define TMR8_CS_DIV64     3'h3
`define TMR8_CS_DIV256    3'h4
`define TMR8_CS_DIV1024   3'h5
`define TMR8_CS_EXT_FALL  3'h6
`define TMR8_CS_EXT_RISE  3'h7

// counting kinds derived from the waveform mode
`define TMR8_KIND_PLAIN   2'h0
`define TMR8_KIND_FAST    2'h1
`define TMR8_KIND_PHASE   2'h2

`endif

// [src/tmr8_tick_sel.v]
// tmr8_tick_sel.v: timer tick source selection, internal prescaler and
// external count input synchroniser; assumes one clock mclk and a synchronous reset.
`timescale 1ns/1ns
`default_nettype none
`include "tmr8_defines.vh"

module tmr8_tick_sel
(
  // clock and reset
  input  wire       mclk,
  input  wire       sys_rst,
  // control
  input  wire       tick_enable,
  input  wire [2:0] clock_select_field,
  // external count pin
  input  wire       ext_count_input,
  // tick out, one cycle pulse per tick, held high every cycle when dividing by one
  output reg        timer_tick
);

  reg [9:0] presc_q;
  reg       sync1_q;
  reg       sync2_q;
  reg       sync3_q;
  reg       ext_level_q;
  reg       ext_prev_q;

  // free prescaler, cleared while disabled or stopped
  always @(posedge mclk)
  begin
    if (sys_rst || !tick_enable || clock_select_field == `TMR8_CS_STOP)
      presc_q <= 10'h000;
    else
      presc_q <= presc_q + 10'h001;
  end

  // three stage synchroniser, level taken once stages two and three agree
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sync1_q     <= 1'b0;
      sync2_q     <= 1'b0;
      sync3_q     <= 1'b0;
      ext_level_q <= 1'b0;
      ext_prev_q  <= 1'b0;
    end
    else
    begin
      sync1_q <= ext_count_input;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q)
        ext_level_q <= sync3_q;
      ext_prev_q <= ext_level_q;
    end
  end

  // source and edge selection
  always @*
  begin
    timer_tick = 1'b0;
    if (tick_enable)
    begin
      case (clock_select_field)
        `TMR8_CS_STOP:     timer_tick = 1'b0;
        `TMR8_CS_DIV1:     timer_tick = 1'b1;
        `TMR8_CS_DIV8:     timer_tick = (presc_q[2:0] == 3'h7);
        `TMR8_CS_DIV64:    timer_tick = (presc_q[5:0] == 6'h3F);
        `TMR8_CS_DIV256:   timer_tick = (presc_q[7:0] == 8'hFF);
        `TMR8_CS_DIV1024:  timer_tick = (presc_q == 10'h3FF);
        `TMR8_CS_EXT_FALL: timer_tick = ext_prev_q & ~ext_level_q;
        `TMR8_CS_EXT_RISE: timer_tick = ~ext_prev_q & ext_level_q;
        default:           timer_tick = 1'b0;
      endcase
    end
  end

endmodule // tmr8_tick_sel
`default_nettype wire

// [src/tmr8_core.v]
// tmr8_core.v: 8-bit timer counter core with two compare channels,
// register file, flags, double buffered compares and waveform outputs.
// assumes a single clock mclk, a synchronous active high reset and a
// register master that never strobes read and write together.
`timescale 1ns/1ns
`default_nettype none
`include "tmr8_defines.vh"

module tmr8_core
(
  // clock and reset
  input  wire       mclk,
  input  wire       sys_rst,
  // register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // external count pin
  input  wire       ext_count_input,
  // compare output pins
  output wire       compare_out_a,
  output wire       compare_out_a_en,
  output wire       compare_out_b,
  output wire       compare_out_b_en,
  // interrupt requests and service acknowledges
  output wire       irq_ovf_req,
  output wire       irq_cmp_a_req,
  output wire       irq_cmp_b_req,
  input  wire       irq_ovf_ack,
  input  wire       irq_cmp_a_ack,
  input  wire       irq_cmp_b_ack
);

  reg  [7:0] ctrl_reg_a_q;
  reg  [7:0] ctrl_reg_b_q;
  reg  [7:0] counter_value_q, counter_value_d;
  reg  [7:0] cmp_buf_a_q, cmp_buf_b_q;
  reg  [7:0] compare_value_a_q, compare_value_b_q;
  reg  [2:0] irq_mask_reg_q;
  reg  [2:0] irq_flag_reg_q, irq_flag_reg_d;
  reg        power_reduce_bit_q;
  reg        count_down_q, count_down_d;
  reg        match_block_q;
  reg        oc_a_q, oc_b_q;
  reg  [7:0] read_mux;
  reg  [1:0] count_kind;
  reg        ovf_event, buf_load;
  wire       timer_tick;
  wire [2:0] wave_mode;
  wire [2:0] clock_select_field;
  wire [1:0] com_a, com_b;
  wire [7:0] top_value;
  wire       match_a, match_b;
  wire       hit_a, hit_b;
  wire       cnt_write;
  wire       at_bottom, at_top;

  // register write decode
  function wr_hit;
    input [3:0] ofs;
    begin
      wr_hit = reg_wr && (reg_addr == ofs);
    end
  endfunction

  // next state of a compare output register
  function oc_next;
    input [1:0] kind;
    input [1:0] com;
    input       cur;
    input       hit;
    input       bot;
    input       down;
    begin
      oc_next = cur;
      if (com != 2'h0)
        case (kind)
          `TMR8_KIND_FAST:
            if (bot)
              oc_next = (com == 2'h2);
            else if (hit)
              oc_next = (com == 2'h3);
          `TMR8_KIND_PHASE:
            if (hit)
              oc_next = (com == 2'h2) ? down : ~down;
          default:
            if (hit)
              oc_next = (com == 2'h1) ? ~cur : (com == 2'h3);
        endcase
    end
  endfunction

  // field views
  assign wave_mode = {ctrl_reg_b_q[`TMR8_WM_HIGH_BIT], ctrl_reg_a_q[`TMR8_WM_BIT1],
                      ctrl_reg_a_q[`TMR8_WM_BIT0]};
  assign clock_select_field = ctrl_reg_b_q[`TMR8_CS_LSB +: 3];
  assign com_a = ctrl_reg_a_q[`TMR8_COM_A_LSB +: 2];
  assign com_b = ctrl_reg_a_q[`TMR8_COM_B_LSB +: 2];
  assign cnt_write = wr_hit(`TMR8_OFS_COUNT);

  // tick source
  tmr8_tick_sel u_tick_sel
  (
    .mclk               (mclk),
    .sys_rst            (sys_rst),
    .tick_enable        (~power_reduce_bit_q),
    .clock_select_field (clock_select_field),
    .ext_count_input    (ext_count_input),
    .timer_tick         (timer_tick)
  );

  // counting kind from waveform mode; reserved codes count as normal
  always @*
  begin
    case (wave_mode)
      3'h1, 3'h5: count_kind = `TMR8_KIND_PHASE;
      3'h3, 3'h7: count_kind = `TMR8_KIND_FAST;
      default:    count_kind = `TMR8_KIND_PLAIN;
    endcase
  end

  // top, bottom and continuous compare
  assign top_value = (wave_mode == 3'h2 || wave_mode == 3'h5 || wave_mode == 3'h7) ?
                     compare_value_a_q : `TMR8_MAX;
  assign at_bottom = (counter_value_q == `TMR8_BOTTOM);
  assign at_top    = (counter_value_q == top_value);
  assign match_a   = (counter_value_q == compare_value_a_q);
  assign match_b   = (counter_value_q == compare_value_b_q);
  assign hit_a     = timer_tick & match_a & ~match_block_q;
  assign hit_b     = timer_tick & match_b & ~match_block_q;

  // counter next value, software write wins
  always @*
  begin
    counter_value_d = counter_value_q;
    count_down_d    = count_down_q;
    ovf_event       = 1'b0;
    buf_load        = 1'b0;
    if (timer_tick)
    begin
      case (count_kind)
        `TMR8_KIND_FAST:
        begin
          buf_load = at_top;
          ovf_event = at_top;
          counter_value_d = at_top ? `TMR8_BOTTOM : counter_value_q + 8'h01;
        end
        `TMR8_KIND_PHASE:
        begin
          if (!count_down_q)
          begin
            buf_load = at_top;
            if (at_top && !at_bottom)
            begin
              count_down_d    = 1'b1;
              counter_value_d = counter_value_q - 8'h01;
            end
            else if (!at_top)
              counter_value_d = counter_value_q + 8'h01;
          end
          else if (at_bottom)
          begin
            ovf_event       = 1'b1;
            count_down_d    = 1'b0;
            counter_value_d = counter_value_q + 8'h01;
          end
          else
            counter_value_d = counter_value_q - 8'h01;
        end
        default:
        begin
          ovf_event = (counter_value_q == `TMR8_MAX);
          if (wave_mode == 3'h2 && match_a)
            counter_value_d = `TMR8_BOTTOM;
          else
            counter_value_d = counter_value_q + 8'h01;
        end
      endcase
    end
    if (cnt_write)
    begin
      counter_value_d = reg_wdata;
      ovf_event       = 1'b0;
    end
  end

  // flags: hardware set wins over service or software clear
  always @*
  begin
    irq_flag_reg_d = irq_flag_reg_q;
    if (wr_hit(`TMR8_OFS_IRQ_FLAG))
      irq_flag_reg_d = irq_flag_reg_d & ~reg_wdata[2:0];
    if (irq_ovf_ack)
      irq_flag_reg_d[`TMR8_IRQ_OVF] = 1'b0;
    if (irq_cmp_a_ack)
      irq_flag_reg_d[`TMR8_IRQ_CMP_A] = 1'b0;
    if (irq_cmp_b_ack)
      irq_flag_reg_d[`TMR8_IRQ_CMP_B] = 1'b0;
    if (ovf_event)
      irq_flag_reg_d[`TMR8_IRQ_OVF] = 1'b1;
    if (hit_a)
      irq_flag_reg_d[`TMR8_IRQ_CMP_A] = 1'b1;
    if (hit_b)
      irq_flag_reg_d[`TMR8_IRQ_CMP_B] = 1'b1;
  end

  // counter, direction, blocking and waveform state
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      counter_value_q <= `TMR8_RST_BYTE;
      count_down_q    <= 1'b0;
      match_block_q   <= 1'b0;
      irq_flag_reg_q  <= `TMR8_RST_IRQ;
      oc_a_q          <= 1'b0;
      oc_b_q          <= 1'b0;
    end
    else
    begin
      counter_value_q <= counter_value_d;
      count_down_q    <= count_down_d;
      irq_flag_reg_q  <= irq_flag_reg_d;
      // block held from a counter write until the next tick has passed
      if (cnt_write)
        match_block_q <= 1'b1;
      else if (timer_tick)
        match_block_q <= 1'b0;
      oc_a_q <= oc_next(count_kind, com_a, oc_a_q, hit_a, ovf_event, count_down_q);
      oc_b_q <= oc_next(count_kind, com_b, oc_b_q, hit_b, ovf_event, count_down_q);
    end
  end

  // software registers
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ctrl_reg_a_q       <= `TMR8_RST_BYTE;
      ctrl_reg_b_q       <= `TMR8_RST_BYTE;
      cmp_buf_a_q        <= `TMR8_RST_BYTE;
      cmp_buf_b_q        <= `TMR8_RST_BYTE;
      irq_mask_reg_q     <= `TMR8_RST_IRQ;
      power_reduce_bit_q <= 1'b0;
    end
    else
    begin
      if (wr_hit(`TMR8_OFS_CTRL_A))
        ctrl_reg_a_q <= reg_wdata & `TMR8_CTRL_A_MASK;
      if (wr_hit(`TMR8_OFS_CTRL_B))
        ctrl_reg_b_q <= reg_wdata & `TMR8_CTRL_B_MASK;
      if (wr_hit(`TMR8_OFS_CMP_A))
        cmp_buf_a_q <= reg_wdata;
      if (wr_hit(`TMR8_OFS_CMP_B))
        cmp_buf_b_q <= reg_wdata;
      if (wr_hit(`TMR8_OFS_IRQ_MASK))
        irq_mask_reg_q <= reg_wdata[2:0];
      if (wr_hit(`TMR8_OFS_POWER))
        power_reduce_bit_q <= reg_wdata[`TMR8_POWER_BIT];
    end
  end

  // active compare values: direct in plain modes, reloaded at top in pwm modes
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      compare_value_a_q <= `TMR8_RST_BYTE;
      compare_value_b_q <= `TMR8_RST_BYTE;
    end
    else if (count_kind == `TMR8_KIND_PLAIN || buf_load)
    begin
      compare_value_a_q <= cmp_buf_a_q;
      compare_value_b_q <= cmp_buf_b_q;
    end
  end

  // read mux; unmapped offsets read zero
  always @*
  begin
    case (reg_addr)
      `TMR8_OFS_CTRL_A:   read_mux = ctrl_reg_a_q;
      `TMR8_OFS_CTRL_B:   read_mux = ctrl_reg_b_q;
      `TMR8_OFS_COUNT:    read_mux = counter_value_q;
      `TMR8_OFS_CMP_A:    read_mux = cmp_buf_a_q;
      `TMR8_OFS_CMP_B:    read_mux = cmp_buf_b_q;
      `TMR8_OFS_IRQ_MASK: read_mux = {5'h00, irq_mask_reg_q};
      `TMR8_OFS_IRQ_FLAG: read_mux = {5'h00, irq_flag_reg_q};
      `TMR8_OFS_POWER:    read_mux = {7'h00, power_reduce_bit_q};
      default:            read_mux = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge mclk)
  begin
    reg_rdata <= (reg_rd && !sys_rst) ? read_mux : 8'h00;
  end

  // masked interrupt requests
  assign irq_ovf_req   = irq_flag_reg_q[`TMR8_IRQ_OVF] & irq_mask_reg_q[`TMR8_IRQ_OVF];
  assign irq_cmp_a_req = irq_flag_reg_q[`TMR8_IRQ_CMP_A] & irq_mask_reg_q[`TMR8_IRQ_CMP_A];
  assign irq_cmp_b_req = irq_flag_reg_q[`TMR8_IRQ_CMP_B] & irq_mask_reg_q[`TMR8_IRQ_CMP_B];

  // pin override while a compare output mode is chosen
  assign compare_out_a    = oc_a_q;
  assign compare_out_a_en = (com_a != 2'h0);
  assign compare_out_b    = oc_b_q;
  assign compare_out_b_en = (com_b != 2'h0);

endmodule // tmr8_core
`default_nettype wire

// [tb/tmr8_chk_properties.sv]
// tmr8_chk_properties.sv: port assertions for tmr8_core
// assumes one clock mclk and a synchronous active high sys_rst
`timescale 1ns/1ns
`default_nettype none
module tmr8_chk
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins and requests
  input wire logic       compare_out_a_en,
  input wire logic       compare_out_b_en,
  input wire logic       irq_ovf_req,
  input wire logic       irq_cmp_a_req,
  input wire logic       irq_cmp_b_req,
  input wire logic       irq_ovf_ack
);
  logic [2:0] cs_q;
  logic       pw_q;
  logic [2:0] quiet_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // shadow of clock select and power bit
  always_ff @(posedge mclk)
    if (sys_rst) {cs_q, pw_q} <= 4'h0;
    else if (reg_wr && reg_addr == 4'h1) cs_q <= reg_wdata[2:0];
    else if (reg_wr && reg_addr == 4'h7) pw_q <= reg_wdata[0];
  // cycles since ticks were last allowed, lets the tick pipe drain
  always_ff @(posedge mclk)
    if (sys_rst || (cs_q != 3'h0 && !pw_q)) quiet_q <= 3'h0;
    else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside answer");
  rd_unmap_a: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  mask_gate_a:
    assert property (reg_wr && reg_addr == 4'h5 && reg_wdata[2:0] == 3'h0
      |=> !irq_ovf_req && !irq_cmp_a_req && !irq_cmp_b_req)
    else $error("masked request still high");
  flag_hold_a: assert property (irq_ovf_req && !irq_ovf_ack && !reg_wr |=> irq_ovf_req)
    else $error("overflow request dropped");
  ack_clear_a: assert property (irq_ovf_ack && quiet_q > 3'h3 |=> !irq_ovf_req)
    else $error("ack left request high");
  stop_quiet_a:
    assert property (cs_q == 3'h0 && quiet_q > 3'h3 && !reg_wr
      |=> !$rose(irq_ovf_req) && !$rose(irq_cmp_a_req) && !$rose(irq_cmp_b_req))
    else $error("flag rose while stopped");
  power_quiet_a:
    assert property (pw_q && quiet_q > 3'h3 && !reg_wr
      |=> !$rose(irq_ovf_req) && !$rose(irq_cmp_a_req))
    else $error("flag rose while powered down");
  pin_en_a:
    assert property (reg_wr && reg_addr == 4'h0 |=> compare_out_a_en == (|$past(reg_wdata[7:6]))
      && compare_out_b_en == (|$past(reg_wdata[5:4])))
    else $error("pin enable wrong");
  ovf_c: cover property ($rose(irq_ovf_req));
  cmp_c: cover property ($rose(irq_cmp_a_req));
  ack_c: cover property (irq_ovf_ack && irq_ovf_req);
endmodule // tmr8_chk

bind tmr8_core tmr8_chk u_chk
(
  .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .compare_out_a_en(compare_out_a_en), .compare_out_b_en(compare_out_b_en),
  .irq_ovf_req(irq_ovf_req), .irq_cmp_a_req(irq_cmp_a_req),
  .irq_cmp_b_req(irq_cmp_b_req), .irq_ovf_ack(irq_ovf_ack)
);
`default_nettype wire

// [tb/tmr8_ext_model.sv]
// tmr8_ext_model.sv: external count source and compare pin watcher
// assumes one clock mclk; the pin changes just after rising edges
`timescale 1ns/1ns
`default_nettype none
module tmr8_ext_model
(
  // clock
  input  wire logic       mclk,
  // pins
  input  wire logic       compare_out_a,
  input  wire logic       compare_out_a_en,
  output var  logic       ext_count_input,
  output wire logic [7:0] toggle_cnt
);
  logic [7:0] cnt_q = 8'h00;
  logic       last_q = 1'b0;
  initial ext_count_input = 1'b0;
  assign toggle_cnt = cnt_q;
  // count level changes of the driven compare pin
  always @(posedge mclk)
  begin
    last_q <= compare_out_a;
    cnt_q  <= cnt_q + {7'h0, compare_out_a_en && (compare_out_a != last_q)};
  end
  // each level held hold cycles, at least two, so one edge gives one tick
  task automatic pulses(input int n, input int hold);
    repeat (n)
    begin
      @(posedge mclk);
      ext_count_input <= 1'b1;
      repeat (hold) @(posedge mclk);
      ext_count_input <= 1'b0;
      repeat (hold - 1) @(posedge mclk);
    end
  endtask
endmodule // tmr8_ext_model
`default_nettype wire

// [tb/tb_timer8_counter_core.sv]
// tb_timer8_counter_core.sv: self-checking bench for tmr8_core
// assumes the checker bind and the pin model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_timer8_counter_core;
  logic       mclk;
  logic       sys_rst;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [2:0] ack;
  logic [7:0] rv;
  wire  [7:0] reg_rdata;
  wire  [7:0] toggles;
  wire  [2:0] req;
  wire        ext_pin;
  wire        out_a;
  wire        out_a_en;
  wire        out_b;
  wire        out_b_en;
  int         err_count = 0;
  int         n_tests = 0;
  // block and far side
  tmr8_core DUT
  (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_input(ext_pin),
    .compare_out_a(out_a), .compare_out_a_en(out_a_en), .compare_out_b(out_b),
    .compare_out_b_en(out_b_en), .irq_ovf_req(req[0]), .irq_cmp_a_req(req[1]),
    .irq_cmp_b_req(req[2]), .irq_ovf_ack(ack[0]), .irq_cmp_a_ack(ack[1]),
    .irq_cmp_b_ack(ack[2])
  );
  tmr8_ext_model u_ext
  (
    .mclk(mclk), .compare_out_a(out_a), .compare_out_a_en(out_a_en),
    .ext_count_input(ext_pin), .toggle_cnt(toggles)
  );
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // compare and count
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bus write and read, read data taken one cycle after the strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // reset values, field masks, unmapped place
  task automatic t_regs;
    logic [7:0] ev [8] = '{8'hF3, 8'h08, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h00, 8'h01};
    for (int a = 0; a < 16; a++)
    begin
      rd(4'(a));
      chk("reset value", 8'h00, rv);
    end
    for (int a = 0; a < 8; a++)
      wr(4'(a), (a == 1) ? 8'hF8 : 8'hFF);
    wr(4'hB, 8'hFF);
    chk("pin enables", 8'h03, {6'h0, out_a_en, out_b_en});
    for (int a = 0; a < 9; a++)
    begin
      rd((a == 8) ? 4'hB : 4'(a));
      chk("readback", (a == 8) ? 8'h00 : ev[a], rv);
    end
    for (int a = 0; a < 8; a++)
      wr(4'(a), 8'h00);
    $display("t_regs done");
  endtask
  // normal mode wrap, overflow flag and service clear
  task automatic t_normal;
    int n = 0;
    wr(4'h5, 8'h01);
    wr(4'h2, 8'hFC);
    wr(4'h1, 8'h01);
    while (req[0] !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      #1 n++;
    end
    chk("wrap delay", 8'h01, {7'h0, n == 4});
    wr(4'h1, 8'h00);
    rd(4'h6);
    // both compares sit at zero, so the tick after the wrap matches them too
    chk("overflow flag", 8'h07, rv);
    idle(6);
    ack <= 3'b111;
    @(posedge mclk);
    ack <= 3'b000;
    #1 chk("ack clears", 8'h00, {7'h0, req[0]});
    rd(4'h6);
    chk("ack clears all", 8'h00, rv);
    $display("t_normal done");
  endtask
  // clear on match, compare flag, toggle output, write-one clear
  task automatic t_ctc;
    logic [7:0] base;
    wr(4'h3, 8'h03);
    wr(4'h5, 8'h06);
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h72);
    wr(4'h1, 8'h01);
    for (int i = 0; i < 10; i++)
    begin
      rd(4'h2);
      chk("count within top", 8'h01, {7'h0, rv <= 8'h03});
    end
    base = toggles;
    idle(40);
    chk("toggle rate", 8'h01, {7'h0, 8'(toggles - base) inside {[9:11]}});
    chk("compare request", 8'h03, {6'h0, req[2:1]});
    chk("set on match b", 8'h01, {7'h0, out_b});
    wr(4'h1, 8'h00);
    idle(6);
    wr(4'h6, 8'h06);
    #1 chk("flag write clear", 8'h00, {6'h0, req[2:1]});
    wr(4'h0, 8'h00);
    $display("t_ctc done");
  endtask
  // match blocking, write priority, power bit
  task automatic t_block;
    wr(4'h3, 8'h20);
    wr(4'h2, 8'h20);
    wr(4'h1, 8'h01);
    idle(8);
    chk("blocked match", 8'h00, {7'h0, req[1]});
    wr(4'h2, 8'h80);
    rd(4'h2);
    chk("write wins", 8'h01, {7'h0, rv >= 8'h80 && rv <= 8'h84});
    wr(4'h7, 8'h01);
    wr(4'h2, 8'h40);
    idle(20);
    rd(4'h2);
    chk("power held", 8'h40, rv);
    wr(4'h7, 8'h00);
    idle(4);
    rd(4'h2);
    chk("power released", 8'h01, {7'h0, rv != 8'h40});
    wr(4'h1, 8'h00);
    $display("t_block done");
  endtask
  // external edges and every prescaler step
  task automatic t_ext;
    int dv [4] = '{8, 64, 256, 1024};
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h07);
    u_ext.pulses(5, 4);
    idle(8);
    rd(4'h2);
    chk("rising edges", 8'h05, rv);
    wr(4'h1, 8'h06);
    u_ext.pulses(3, 3);
    idle(8);
    rd(4'h2);
    chk("falling edges", 8'h08, rv);
    for (int k = 0; k < 4; k++)
    begin
      wr(4'h2, 8'h00);
      wr(4'h1, 8'(k + 2));
      idle(dv[k] * 10);
      wr(4'h1, 8'h00);
      rd(4'h2);
      chk("prescaled count", 8'h01, {7'h0, rv inside {[8'h09:8'h0B]}});
    end
    $display("t_ext done");
  endtask
  // phase correct count up to compare a and back, overflow at bottom
  task automatic t_pwm;
    wr(4'h3, 8'h04);
    wr(4'h2, 8'h00);
    wr(4'h6, 8'h07);
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h09);
    for (int i = 0; i < 10; i++)
    begin
      rd(4'h2);
      chk("phase count", 8'h01, {7'h0, rv <= 8'h04});
    end
    wr(4'h1, 8'h00);
    rd(4'h6);
    chk("bottom overflow", 8'h01, rv & 8'h01);
    $display("t_pwm done");
  endtask
  // counts and verdict, then stop
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, ack} = '0;
    sys_rst = 1'b1;
    idle(16);
    sys_rst <= 1'b0;
    t_regs;
    t_normal;
    t_ctc;
    t_block;
    t_ext;
    t_pwm;
    give_verdict;
  end
  // hang guard, well past the expected run
  initial
  begin
    #400000;
    err_count++;
    $display("[ERR] watchdog expected done seen hang");
    give_verdict;
  end
endmodule // tb_timer8_counter_core
`default_nettype wire
